// file: rtl/i2c_slave_status_buffer.sv
// Design decision made here: the AHB-Lite slave port.
`timescale 1ns/1ps
module i2c_slave_status_buffer (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // byte event to the cpu
  output logic byte_irq,
  // bus
  i2c_link_if.device link
);
  import i2c_pkg::*;

  typedef enum logic [1:0] {PH_IDLE, PH_ADDR, PH_DATA, PH_SKIP} phase_e;

  phase_e phase_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic scl_h_q, sda_h_q, scl_f_q, sda_f_q, scl_p_q, sda_p_q;
  logic [7:0] addr_q, cfg_q, port_q, pre_q, buf_q, rx_q;
  logic start_q, stop_q, dir_q, ad_q, full_q, ack_q, write_collision_flag_q, ovr_q;
  logic [3:0] cnt_q;
  logic [3:0] txi_q;
  logic ack_drv_q;
  logic txn_q;
  logic [2:0] dly_q;
  logic scl_oe_q, sda_oe_q;
  logic ap_q;
  logic [7:0] ofs_q;
  logic acc, en, active, scl_rise, scl_fall, start_det, stop_det;
  logic ev8, ev9, ack_rise, match, tx_next, buf_ok, cpu_buf_wr;
  logic cpu_buf_rd, pf_load, wr_stat, rel_clr;

  // ----------------------------------------------------------------
  // event decode
  // ----------------------------------------------------------------
  assign acc = hsel & htrans[1] & hready;
  assign en = cfg_q[CFG_EN];
  assign active = phase_q == PH_ADDR || phase_q == PH_DATA;
  assign scl_rise = scl_f_q & ~scl_p_q;
  assign scl_fall = ~scl_f_q & scl_p_q;
  assign start_det = scl_f_q & scl_p_q & ~sda_f_q & sda_p_q;
  assign stop_det = scl_f_q & scl_p_q & sda_f_q & ~sda_p_q;
  assign ev8 = active && scl_fall && cnt_q == 4'h8;
  assign ev9 = active && scl_fall && cnt_q == 4'h9;
  assign ack_rise = active && scl_rise && cnt_q == 4'h8;
  assign match = rx_q[7:1] == addr_q[7:1];
  assign tx_next = (phase_q == PH_ADDR && ack_drv_q && rx_q[0]) ||
    (phase_q == PH_DATA && dir_q && !ack_q);
  assign buf_ok = dir_q & cfg_q[CFG_RD_STRETCH] & ~cfg_q[CFG_RELEASE];
  assign cpu_buf_wr = ap_q && ofs_q == OFS_SHIFT;
  assign cpu_buf_rd = acc && !hwrite && haddr[7:0] == OFS_SHIFT;
  assign wr_stat = ap_q && ofs_q == OFS_STATUS;
  assign pf_load = dly_q == 3'h1;
  assign rel_clr = ev9 && ((cfg_q[CFG_RD_STRETCH] && tx_next) ||
    (cfg_q[CFG_WR_STRETCH] && phase_q == PH_DATA && !dir_q));
  assign link.dev_scl_o = 1'b0;
  assign link.dev_sda_o = 1'b0;
  assign link.dev_scl_oe = scl_oe_q;
  assign link.dev_sda_oe = sda_oe_q;

  // ----------------------------------------------------------------
  // bus slave: zero wait states, reads registered in address phase
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      ofs_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_q <= acc & hwrite;
      ofs_q <= haddr[7:0];
      if (acc && !hwrite) begin
        case (haddr[7:0])
          OFS_ADDR: hrdata <= {24'h000000, addr_q};
          OFS_SHIFT: hrdata <= {24'h000000, buf_q};
          OFS_CONFIG: hrdata <= {24'h000000, cfg_q};
          OFS_STATUS: hrdata <= {24'h000000, start_q, stop_q, dir_q, ad_q,
            full_q, ack_q, write_collision_flag_q, ovr_q};
          OFS_PREFETCH: hrdata <= {24'h000000, pre_q};
          OFS_PORT: hrdata <= {24'h000000, port_q};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // plain control registers; hardware may drop the release bit
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= ADDR_RST;
      cfg_q <= CONFIG_RST;
      port_q <= PORT_RST;
      pre_q <= PREFETCH_RST;
    end else if (clk_en) begin
      if (ap_q && ofs_q == OFS_ADDR) addr_q <= hwdata[7:0];
      if (ap_q && ofs_q == OFS_CONFIG) cfg_q <= hwdata[7:0];
      if (ap_q && ofs_q == OFS_PORT) port_q <= {5'h00, hwdata[2:0]};
      if (ap_q && ofs_q == OFS_PREFETCH) pre_q <= hwdata[7:0];
      // stalling wins so the master never runs ahead of software
      if (rel_clr) cfg_q[CFG_RELEASE] <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // pin sampling and optional glitch filter
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
      {scl_h_q, sda_h_q, scl_f_q, sda_f_q, scl_p_q, sda_p_q} <= 6'h3F;
    end else if (clk_en) begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
      scl_h_q <= scl_sync_q[1];
      sda_h_q <= sda_sync_q[1];
      // filter needs two equal samples, adding one clock of delay
      if (!port_q[PORT_FILTER] || scl_sync_q[1] == scl_h_q) begin
        scl_f_q <= scl_sync_q[1];
      end
      if (!port_q[PORT_FILTER] || sda_sync_q[1] == sda_h_q) begin
        sda_f_q <= sda_sync_q[1];
      end
      scl_p_q <= scl_f_q;
      sda_p_q <= sda_f_q;
    end
  end

  // ----------------------------------------------------------------
  // byte sequencer
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      phase_q <= PH_IDLE;
      cnt_q <= 4'h0;
      txi_q <= 4'h8;
      rx_q <= 8'h00;
      ack_drv_q <= 1'b0;
      byte_irq <= 1'b0;
      txn_q <= 1'b0;
    end else if (clk_en) begin
      byte_irq <= 1'b0;
      txn_q <= 1'b0;
      if (!en || stop_det) begin
        phase_q <= PH_IDLE;
        ack_drv_q <= 1'b0;
      end else if (start_det) begin
        phase_q <= PH_ADDR;
        cnt_q <= 4'h0;
        txi_q <= 4'h8;
        ack_drv_q <= 1'b0;
      end else if (phase_q != PH_IDLE) begin
        if (scl_rise) begin
          if (cnt_q < 4'h8) rx_q <= {rx_q[6:0], sda_f_q};
          cnt_q <= cnt_q + 4'h1;
        end
        if (scl_fall && cnt_q < 4'h8 && cnt_q != 4'h0) txi_q <= cnt_q;
        if (ev8) begin
          txi_q <= 4'h8;
          ack_drv_q <= (phase_q == PH_ADDR && match) ||
            (phase_q == PH_DATA && !dir_q && !full_q);
        end
        if (ev9) begin
          cnt_q <= 4'h0;
          txi_q <= 4'h0;
          ack_drv_q <= 1'b0;
          if (phase_q == PH_ADDR) phase_q <= ack_drv_q ? PH_DATA : PH_SKIP;
          else if (dir_q && ack_q) phase_q <= PH_SKIP;
          byte_irq <= (phase_q == PH_ADDR && ack_drv_q) ||
            (phase_q == PH_DATA && !dir_q) || tx_next;
          txn_q <= tx_next;
        end
      end
    end
  end

  // prefetch countdown from the byte event
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dly_q <= 3'h0;
    end else if (clk_en) begin
      if (txn_q && !cfg_q[CFG_RD_STRETCH]) dly_q <= PREFETCH_DLY;
      else if (dly_q != 3'h0) dly_q <= dly_q - 3'h1;
    end
  end

  // ----------------------------------------------------------------
  // status flags; a hardware set wins over a software clear
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {start_q, stop_q, dir_q, ad_q} <= 4'h4;
      {full_q, ack_q, write_collision_flag_q, ovr_q} <= 4'h4;
      buf_q <= 8'h00;
    end else if (clk_en) begin
      if (start_det) begin
        start_q <= 1'b1;
        stop_q <= 1'b0;
        ack_q <= 1'b0;
      end
      if (stop_det) begin
        stop_q <= 1'b1;
        start_q <= 1'b0;
      end
      if (start_det || stop_det || (ack_rise && sda_f_q)) begin
        dir_q <= 1'b0;
      end else if (ev9 && phase_q == PH_ADDR && ack_drv_q) begin
        dir_q <= rx_q[0];
      end
      if (ev8) ad_q <= phase_q == PH_DATA;
      if (ack_rise) ack_q <= sda_f_q;
      // full flag moves only through these side effects
      if (ev8 && phase_q == PH_DATA && !dir_q && !full_q) begin
        buf_q <= rx_q;
        full_q <= 1'b1;
      end else if (cpu_buf_wr && buf_ok) begin
        buf_q <= hwdata[7:0];
        full_q <= 1'b1;
      end else if (pf_load) begin
        buf_q <= pre_q;
        full_q <= 1'b1;
      end else if (cpu_buf_rd || (ev8 && phase_q == PH_DATA && dir_q)) begin
        full_q <= 1'b0;
      end
      if (ev8 && phase_q == PH_DATA && !dir_q && full_q) begin
        ovr_q <= 1'b1;
      end else if (wr_stat && !hwdata[ST_OVR]) begin
        ovr_q <= 1'b0;
      end
      if (cpu_buf_wr && !buf_ok) begin
        write_collision_flag_q <= 1'b1;
      end else if (wr_stat && !hwdata[ST_WRITE_COLLISION_FLAG]) begin
        write_collision_flag_q <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // line drivers; both released while the block is disabled
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (clk_en) begin
      scl_oe_q <= en & ~cfg_q[CFG_RELEASE];
      sda_oe_q <= en && (ack_drv_q || (phase_q == PH_DATA && dir_q &&
        txi_q < 4'h8 && !buf_q[3'(4'h7 - txi_q)]));
    end
  end
endmodule : i2c_slave_status_buffer

// file: rtl/i2c_pkg.sv
package i2c_pkg;
  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_NS = 40;
  localparam int LINK_HALF_NS = 320; // master-made scl half period
  localparam int LINK_HALF_CYC = (LINK_HALF_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [2:0] PREFETCH_DLY = 3'h2; // clocks after byte event

  // ----------------------------------------------------------------
  // slave register map, fields and reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_ADDR = 8'h00;
  localparam logic [7:0] OFS_SHIFT = 8'h04;
  localparam logic [7:0] OFS_CONFIG = 8'h08;
  localparam logic [7:0] OFS_STATUS = 8'h0C;
  localparam logic [7:0] OFS_PREFETCH = 8'h10;
  localparam logic [7:0] OFS_PORT = 8'h44;
  localparam int CFG_EN = 0;
  localparam int CFG_RELEASE = 2;
  localparam int CFG_WR_STRETCH = 3;
  localparam int CFG_RD_STRETCH = 4;
  localparam int PORT_FILTER = 2;
  localparam int ST_OVR = 0;
  localparam int ST_WRITE_COLLISION_FLAG = 1;
  localparam logic [7:0] ADDR_RST = 8'h00;
  localparam logic [7:0] CONFIG_RST = 8'h10;
  localparam logic [7:0] PORT_RST = 8'h02;
  localparam logic [7:0] PREFETCH_RST = 8'h00;

  // ----------------------------------------------------------------
  // master end register map and commands
  // ----------------------------------------------------------------
  localparam logic [7:0] H_OFS_CMD = 8'h00;
  localparam logic [7:0] H_OFS_TX = 8'h04;
  localparam logic [7:0] H_OFS_RX = 8'h08;
  localparam logic [7:0] H_OFS_STAT = 8'h0C;
  localparam int HC_LAST = 3;
  typedef enum logic [2:0] {CMD_NONE, CMD_START, CMD_WRITE, CMD_READ,
    CMD_STOP} cmd_e;
endpackage : i2c_pkg

// file: rtl/i2c_link_if.sv
`timescale 1ns/1ps
interface i2c_link_if;
  logic dev_scl_o;
  logic dev_scl_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic scl;
  logic sda;

  // open-drain wired and; an enabled driver with output 0 pulls low
  assign scl = ~((dev_scl_oe & ~dev_scl_o) | (host_scl_oe & ~host_scl_o));
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (host_sda_oe & ~host_sda_o));

  modport device (output dev_scl_o, dev_scl_oe, dev_sda_o, dev_sda_oe,
    input scl, sda);
  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe,
    input scl, sda);
endinterface : i2c_link_if

// file: rtl/i2c_master_end.sv
`timescale 1ns/1ps
module i2c_master_end (
  // clock, reset, enable
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic clk_en,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // bus
  i2c_link_if.host link
);
  import i2c_pkg::*;

  typedef enum logic [2:0] {HS_IDLE, HS_REL, HS_STA, HS_LOW, HS_HIGH,
    HS_STO1, HS_STO2, HS_STO3} hstate_e;

  hstate_e st_q;
  cmd_e op_q;
  logic [1:0] scl_sync_q;
  logic [1:0] sda_sync_q;
  logic [7:0] tmr_q;
  logic [3:0] bit_q;
  logic [7:0] tx_q;
  logic [7:0] rx_q;
  logic last_q;
  logic nack_q;
  logic scl_oe_q;
  logic sda_oe_q;
  logic ap_q;
  logic [7:0] ofs_q;
  logic acc;
  logic cmd_wr;
  logic half_done;

  assign acc = hsel & htrans[1] & hready;
  assign cmd_wr = ap_q && ofs_q == H_OFS_CMD && st_q == HS_IDLE;
  assign half_done = tmr_q == 8'(LINK_HALF_CYC - 1);
  assign link.host_scl_o = 1'b0;
  assign link.host_sda_o = 1'b0;
  assign link.host_scl_oe = scl_oe_q;
  assign link.host_sda_oe = sda_oe_q;

  // ----------------------------------------------------------------
  // bus slave: zero wait states, read data registered
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ap_q <= 1'b0;
      ofs_q <= 8'h00;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (clk_en) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      ap_q <= acc & hwrite;
      ofs_q <= haddr[7:0];
      if (acc && !hwrite) begin
        case (haddr[7:0])
          H_OFS_TX: hrdata <= {24'h000000, tx_q};
          H_OFS_RX: hrdata <= {24'h000000, rx_q};
          H_OFS_STAT: hrdata <= {30'h0, nack_q, st_q != HS_IDLE};
          default: hrdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // two-stage synchronisers on the wired lines
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_sync_q <= 2'b11;
      sda_sync_q <= 2'b11;
    end else if (clk_en) begin
      scl_sync_q <= {scl_sync_q[0], link.scl};
      sda_sync_q <= {sda_sync_q[0], link.sda};
    end
  end

  // ----------------------------------------------------------------
  // bit engine; a command while busy is dropped
  // ----------------------------------------------------------------
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q <= HS_IDLE;
      op_q <= CMD_NONE;
      tmr_q <= 8'h00;
      bit_q <= 4'h0;
      tx_q <= 8'h00;
      rx_q <= 8'h00;
      last_q <= 1'b0;
      nack_q <= 1'b0;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
    end else if (clk_en) begin
      tmr_q <= half_done ? 8'h00 : tmr_q + 8'h01;
      if (ap_q && ofs_q == H_OFS_TX && st_q == HS_IDLE) begin
        tx_q <= hwdata[7:0];
      end
      case (st_q)
        HS_IDLE: begin
          tmr_q <= 8'h00;
          bit_q <= 4'h0;
          if (cmd_wr) begin
            op_q <= cmd_e'(hwdata[2:0]);
            last_q <= hwdata[HC_LAST];
            case (cmd_e'(hwdata[2:0]))
              CMD_START: begin
                sda_oe_q <= 1'b0;
                scl_oe_q <= 1'b0;
                st_q <= HS_REL;
              end
              CMD_WRITE, CMD_READ: begin
                nack_q <= 1'b0;
                st_q <= HS_LOW;
              end
              CMD_STOP: st_q <= HS_STO1;
              default: st_q <= HS_IDLE;
            endcase
          end
        end
        HS_REL: begin
          // wait for a slave that still stretches scl
          if (!scl_sync_q[1]) tmr_q <= 8'h00;
          else if (half_done) begin
            sda_oe_q <= 1'b1;
            st_q <= HS_STA;
          end
        end
        HS_STA: if (half_done) begin
          scl_oe_q <= 1'b1;
          st_q <= HS_IDLE;
        end
        HS_LOW: begin
          scl_oe_q <= 1'b1;
          if (bit_q < 4'h8) sda_oe_q <= (op_q == CMD_WRITE) ? ~tx_q[7] : 1'b0;
          else sda_oe_q <= (op_q == CMD_READ) & ~last_q;
          if (half_done) begin
            scl_oe_q <= 1'b0;
            st_q <= HS_HIGH;
          end
        end
        HS_HIGH: begin
          if (!scl_sync_q[1]) tmr_q <= 8'h00;
          else if (half_done) begin
            scl_oe_q <= 1'b1;
            bit_q <= bit_q + 4'h1;
            if (bit_q < 4'h8) begin
              rx_q <= {rx_q[6:0], sda_sync_q[1]};
              tx_q <= {tx_q[6:0], 1'b0};
              st_q <= HS_LOW;
            end else begin
              if (op_q == CMD_WRITE) nack_q <= sda_sync_q[1];
              // a refused byte ends the transfer with a stop
              st_q <= (op_q == CMD_WRITE && sda_sync_q[1]) ? HS_STO1
                : HS_IDLE;
              sda_oe_q <= 1'b0;
            end
          end
        end
        HS_STO1: begin
          scl_oe_q <= 1'b1;
          sda_oe_q <= 1'b1;
          if (half_done) begin
            scl_oe_q <= 1'b0;
            st_q <= HS_STO2;
          end
        end
        HS_STO2: begin
          if (!scl_sync_q[1]) tmr_q <= 8'h00;
          else if (half_done) begin
            sda_oe_q <= 1'b0;
            st_q <= HS_STO3;
          end
        end
        HS_STO3: if (half_done) st_q <= HS_IDLE;
        default: st_q <= HS_IDLE;
      endcase
    end
  end
endmodule : i2c_master_end

// file: verification/i2c_link_chk.sv
`timescale 1ns/1ps
module i2c_link_chk (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // resolved lines and enables
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_oe,
  input wire logic dev_sda_oe,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe
);
  logic scl_q;
  logic sda_q;
  logic addr_q;
  logic [3:0] cnt_q;
  logic start_ev;
  logic stop_ev;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  // start and stop are the only sda moves allowed while scl is high
  assign start_ev = scl & scl_q & sda_q & ~sda;
  assign stop_ev = scl & scl_q & ~sda_q & sda;

  // line history, released level in reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // bit count per byte; the ack slot ends at the 9th fall
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 4'h0;
      addr_q <= 1'b0;
    end else if (start_ev | stop_ev) begin
      cnt_q <= 4'h0;
      addr_q <= start_ev;
    end else if (scl & ~scl_q) begin
      cnt_q <= cnt_q + 4'h1;
    end else if (~scl & scl_q & (cnt_q == 4'h9)) begin
      cnt_q <= 4'h0;
      addr_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  sequence ack_slot_s;
    scl && !scl_q && cnt_q == 4'h8;
  endsequence

  rst_quiet_a: assert property ($rose(hresetn) |->
    !(dev_sda_oe | dev_scl_oe | host_sda_oe | host_scl_oe))
    else $error("line driven right after reset");
  addr_listen_a: assert property (
    addr_q && cnt_q < 4'h8 |-> !dev_sda_oe)
    else $error("device drives sda during address bits");
  start_quiet_a: assert property (
    start_ev |-> !dev_sda_oe && !dev_scl_oe)
    else $error("device drives a line at start");
  sda_steady_a: assert property (
    scl && scl_q |-> $stable(dev_sda_oe))
    else $error("device sda moved while scl high");
  nack_stop_a: assert property (
    ack_slot_s ##0 sda |-> ##[1:600] stop_ev)
    else $error("no stop after nack");
  stretch_slot_a: assert property (
    $rose(dev_scl_oe) |-> cnt_q == 4'h0)
    else $error("stretch outside byte boundary");
  scl_free_a: assert property (
    $fell(dev_scl_oe) |-> ##[0:20] scl)
    else $error("scl not freed after release");
  stretch_c: cover property ($rose(dev_scl_oe));
endmodule : i2c_link_chk

// file: verification/testbench.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import i2c_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic clk_en = 1'b1;
  logic sel_d = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] d_rdata;
  logic [31:0] h_rdata;
  logic d_rdy;
  logic h_rdy;
  logic hready;
  logic byte_irq;
  int irqs = 0;
  int fail_count = 0;
  int checks = 0;

  // ----------------------------------------------------------------
  // ends and checker
  // ----------------------------------------------------------------
  // one shared bus; sel_d picks the end, its hreadyout is hready
  assign hready = sel_d ? d_rdy : h_rdy;
  i2c_link_if link ();
  i2c_slave_status_buffer i2c_slave_status_buffer_inst (.hclk(hclk),
    .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel & sel_d),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2),
    .hwdata(hwdata), .hready(hready), .hreadyout(d_rdy),
    .hrdata(d_rdata), .hresp(), .byte_irq(byte_irq), .link(link));
  i2c_master_end i2c_master_end_inst (.hclk(hclk), .hresetn(hresetn),
    .clk_en(clk_en), .hsel(hsel & ~sel_d), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hreadyout(h_rdy), .hrdata(h_rdata), .hresp(),
    .link(link));
  i2c_link_chk i2c_link_chk_inst (.hclk(hclk), .hresetn(hresetn),
    .scl(link.scl), .sda(link.sda), .dev_scl_oe(link.dev_scl_oe),
    .dev_sda_oe(link.dev_sda_oe), .host_scl_oe(link.host_scl_oe),
    .host_sda_oe(link.host_sda_oe));

  always #20 hclk = ~hclk;
  // byte event pulses last one cycle, so count every edge
  always @(posedge hclk) if (byte_irq === 1'b1) irqs++;

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic ahb(input logic d, input logic w, input logic [7:0] a,
    input logic [31:0] wd, output logic [31:0] rd);
    @(posedge hclk);
    sel_d <= d;
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = d ? d_rdata : h_rdata;
  endtask : ahb

  task automatic wr(input logic d, input logic [7:0] a, input logic [31:0] v);
    logic [31:0] r;
    ahb(d, 1'b1, a, v, r);
  endtask : wr

  task automatic rc(input logic d, input logic [7:0] a, input logic [31:0] e);
    logic [31:0] r;
    ahb(d, 1'b0, a, 32'h0, r);
    `CHK(r, e)
  endtask : rc

  // host command, then poll busy; the device lags the lines a few clocks
  task automatic cmd(input logic [31:0] c);
    logic [31:0] r;
    r = 32'h1;
    wr(1'b0, H_OFS_CMD, c);
    for (int i = 0; i < 400 && r[0] !== 1'b0; i++) begin
      ahb(1'b0, 1'b0, H_OFS_STAT, 32'h0, r);
    end
    repeat (16) @(posedge hclk);
  endtask : cmd

  task automatic send(input logic [7:0] b);
    wr(1'b0, H_OFS_TX, {24'h0, b});
    cmd(32'(CMD_WRITE));
  endtask : send

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_regs;
    rc(1'b1, OFS_STATUS, 32'h44);
    rc(1'b1, OFS_CONFIG, {24'h0, CONFIG_RST});
    rc(1'b1, OFS_PORT, {24'h0, PORT_RST});
    rc(1'b1, OFS_PREFETCH, {24'h0, PREFETCH_RST});
    rc(1'b1, 8'h20, 32'h0);
    wr(1'b1, OFS_PORT, 32'h6);
    rc(1'b1, OFS_PORT, 32'h6);
    wr(1'b1, OFS_ADDR, 32'h54);
    wr(1'b1, OFS_CONFIG, 32'h5);
    $display("regs done");
  endtask : t_regs

  // write, then overrun on an unread byte
  task automatic t_write;
    int n;
    cmd(32'(CMD_START));
    rc(1'b1, OFS_STATUS, 32'h80);
    send(8'h54);
    rc(1'b0, H_OFS_STAT, 32'h0);
    rc(1'b1, OFS_STATUS, 32'h80);
    n = irqs;
    send(8'hA5);
    `CHK(irqs, n + 1)
    rc(1'b1, OFS_STATUS, 32'h98);
    send(8'h3C);
    rc(1'b0, H_OFS_STAT, 32'h2);
    rc(1'b1, OFS_STATUS, 32'h5D);
    rc(1'b1, OFS_SHIFT, 32'hA5);
    rc(1'b1, OFS_STATUS, 32'h55);
    wr(1'b1, OFS_STATUS, 32'hA);
    rc(1'b1, OFS_STATUS, 32'h54);
    $display("write done");
  endtask : t_write

  task automatic t_coll;
    wr(1'b1, OFS_SHIFT, 32'h11);
    rc(1'b1, OFS_STATUS, 32'h56);
    rc(1'b1, OFS_SHIFT, 32'hA5);
    rc(1'b1, OFS_STATUS, 32'h56);
    wr(1'b1, OFS_STATUS, 32'h1);
    rc(1'b1, OFS_STATUS, 32'h54);
    $display("collision done");
  endtask : t_coll

  // read with prefetch, no stretching
  task automatic t_read;
    wr(1'b1, OFS_PREFETCH, 32'hC3);
    cmd(32'(CMD_START));
    send(8'h55);
    rc(1'b1, OFS_STATUS, 32'hA8);
    wr(1'b1, OFS_PREFETCH, 32'h96);
    cmd(32'(CMD_READ));
    rc(1'b0, H_OFS_RX, 32'hC3);
    cmd(32'hB);
    rc(1'b0, H_OFS_RX, 32'h96);
    rc(1'b1, OFS_STATUS, 32'h94);
    cmd(32'(CMD_STOP));
    rc(1'b1, OFS_STATUS, 32'h54);
    $display("read done");
  endtask : t_read

  // read with stretching: cpu load, then release
  task automatic t_stretch;
    wr(1'b1, OFS_CONFIG, 32'h15);
    cmd(32'(CMD_START));
    send(8'h55);
    rc(1'b1, OFS_STATUS, 32'hA0);
    rc(1'b1, OFS_CONFIG, 32'h11);
    `CHK(link.dev_scl_oe, 1'b1)
    wr(1'b1, OFS_SHIFT, 32'h5A);
    rc(1'b1, OFS_STATUS, 32'hA8);
    wr(1'b1, OFS_CONFIG, 32'h15);
    cmd(32'hB);
    rc(1'b0, H_OFS_RX, 32'h5A);
    rc(1'b1, OFS_STATUS, 32'h94);
    cmd(32'(CMD_STOP));
    cmd(32'(CMD_START));
    send(8'h20);
    rc(1'b0, H_OFS_STAT, 32'h2);
    $display("stretch done");
  endtask : t_stretch

  // write with stretching: bus held until software reads the byte and sets release
  task automatic t_wstretch;
    wr(1'b1, OFS_CONFIG, 32'hD);
    cmd(32'(CMD_START));
    send(8'h54);
    send(8'h77);
    rc(1'b1, OFS_CONFIG, 32'h9);
    `CHK(link.dev_scl_oe, 1'b1)
    rc(1'b1, OFS_SHIFT, 32'h77);
    rc(1'b1, OFS_STATUS, 32'h90);
    wr(1'b1, OFS_CONFIG, 32'hD);
    cmd(32'(CMD_STOP));
    rc(1'b1, OFS_STATUS, 32'h50);
    $display("write stretch done");
  endtask : t_wstretch

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // ----------------------------------------------------------------
  // main sequence and watchdog
  // ----------------------------------------------------------------
  initial begin
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    t_regs;
    t_write;
    t_coll;
    t_read;
    t_stretch;
    t_wstretch;
    end_sim;
  end

  // a stuck bus or busy flag would otherwise hang the run
  initial begin
    repeat (30000) @(posedge hclk);
    fail_count++;
    end_sim;
  end
endmodule : testbench
